// File: src/pss_pkg.sv
// Constants, types and decoding shared by the supervisor and its serial link
// Function
// [R1] Each transfer opens with command byte, address low
// [R2] Command bit seven: zero reads, one writes
// [R3] Host holds chip select high throughout transfer
// [R4] Data pin follows serial clock; driven only for reads
// [R5] Interrupt high while flag set and enabled
// [R6] Low SRAM enable when ram and low select low
// [R7] High SRAM enable likewise; both off when ram high
// [R8] Missing kick within watchdog period forces reset low
// [R9] Reset low on supply fault, watchdog, power-up, button
// [R10] Low reset pin debounced, then reset held 250 ms
// [R11] Reset pin open drain, only pulled low
// [R12] Reset held 250 ms after supply returns
// [R13] All inputs ignored until power-up interval ends; the code still lets alarm match set the flag
// [R14] Timing from 32.768 kHz crystal; halt without crystal
// [R15] Alarm match sets flag; alarm access clears it
// [R16] Flag reaches interrupt only when enable bit set
// [R17] Write protect discards serial register writes; the code still accepts the protect bit of control
// [R18] Supply below trip forces both SRAM enables inactive
// [R19] Watchdog and debounce are parameterised crystal counters
package pss_pkg;
    // Clock rates
    localparam int CLK_HZ = 125000000;
    localparam int XTAL_HZ = 32768;
    // Times in their own units
    localparam int PU_TIME_MS = 250;
    localparam int PB_TIME_MS = 250;
    localparam int DB_TIME_MS = 10;
    localparam int WD_TIME_MS = 1000;
    localparam int XTAL_LOSS_PERIODS = 4;
    // Derived counts: crystal ticks for intervals, main clocks for crystal loss
    localparam int PU_TICKS = (XTAL_HZ * PU_TIME_MS + 999) / 1000;
    localparam int PB_TICKS = (XTAL_HZ * PB_TIME_MS + 999) / 1000;
    localparam int DB_TICKS = (XTAL_HZ * DB_TIME_MS + 999) / 1000;
    localparam int WD_TICKS = (XTAL_HZ * WD_TIME_MS + 999) / 1000;
    localparam int XTAL_LOSS_CYC = (CLK_HZ / XTAL_HZ) * XTAL_LOSS_PERIODS;
    localparam int CNT_W = 17;
    // Command byte layout
    localparam int CMD_RW_BIT = 7;
    localparam int ADDR_W = 7;
    // Register addresses
    localparam logic [6:0] ADDR_ALARM_FIRST = 7'h07;
    localparam logic [6:0] ADDR_ALARM_LAST = 7'h0a;
    localparam logic [6:0] ADDR_CONTROL = 7'h0b;
    localparam logic [6:0] ADDR_STATUS = 7'h0c;
    // Register image slots
    localparam int NUM_REGS = 6;
    localparam logic [2:0] IDX_CONTROL = 3'h4;
    localparam logic [2:0] IDX_STATUS = 3'h5;
    localparam logic [2:0] IDX_NONE = 3'h7;
    // Control and status fields
    localparam int CTRL_WP_BIT = 6;
    localparam int CTRL_AIE_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h80;
    localparam logic [7:0] CTRL_WMASK = 8'hf1;
    localparam logic [7:0] ALARM_RESET = 8'h00;
    localparam int STAT_ALARM_PENDING_FLAG_BIT = 0;
    // Pin synchroniser slots and idle levels
    localparam int SYN_W = 10;
    localparam int S_XTAL = 0;
    localparam int S_SUPPLY = 1;
    localparam int S_RSTPIN = 2;
    localparam int S_KICK = 3;
    localparam int S_RAM = 4;
    localparam int S_LOW = 5;
    localparam int S_HIGH = 6;
    localparam int S_CS = 7;
    localparam int S_ACC = 8;
    localparam int S_WR = 9;
    localparam logic [9:0] SYN_RESET = 10'h07c;

    typedef enum logic [2:0] {
        PSS_CMD = 3'b001,
        PSS_DATA = 3'b010,
        PSS_DONE = 3'b100
    } pss_phase_t;

    // Address to image slot; IDX_NONE for unmapped
    function automatic logic [2:0] pss_index(input logic [6:0] addr);
        logic [6:0] off;
        off = addr - ADDR_ALARM_FIRST;
        if (addr >= ADDR_ALARM_FIRST && addr <= ADDR_ALARM_LAST) begin
            pss_index = off[2:0];
        end else if (addr == ADDR_CONTROL) begin
            pss_index = IDX_CONTROL;
        end else if (addr == ADDR_STATUS) begin
            pss_index = IDX_STATUS;
        end else begin
            pss_index = IDX_NONE;
        end
    endfunction : pss_index
endpackage : pss_pkg

// File: src/pss_link.sv
// Serial command link running on the host serial clock
module pss_link (
    // Link pins
    input wire logic sclk_i,
    input wire logic cs_i,
    input wire logic io_i,
    output logic io_o,
    output logic io_oe_o,
    // From main domain
    input wire logic link_en_i,
    input wire logic [47:0] reg_image_i,
    // To main domain
    output logic acc_tgl_o,
    output logic wr_tgl_o,
    output logic [7:0] cmd_o,
    output logic [7:0] wr_data_o
);
    pss_pkg::pss_phase_t phase_r;
    logic [2:0] cnt_r;
    logic [7:0] shift_r;
    logic [7:0] byte_in;
    logic frame_rst_n;
    logic byte_end;
    logic [2:0] rd_idx;
    logic [7:0] rd_byte;

    // Chip select low aborts the frame at once, no clock needed
    assign frame_rst_n = cs_i & link_en_i; // [R3] [R13]
    assign byte_in = {io_i, shift_r[7:1]};
    assign byte_end = (cnt_r == 3'h7);
    assign rd_idx = pss_pkg::pss_index(cmd_o[6:0]);
    assign rd_byte = (rd_idx == pss_pkg::IDX_NONE) ? 8'h00 : reg_image_i[rd_idx*8 +: 8];

    always_ff @(posedge sclk_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            phase_r <= pss_pkg::PSS_CMD;
            cnt_r <= 3'h0;
            shift_r <= 8'h00;
        end else begin
            cnt_r <= cnt_r + 3'h1;
            shift_r <= byte_in; // [R4]
            unique case (phase_r)
                pss_pkg::PSS_CMD: begin
                    if (byte_end) begin
                        phase_r <= pss_pkg::PSS_DATA; // [R1]
                    end
                end
                pss_pkg::PSS_DATA: begin
                    if (byte_end) begin
                        phase_r <= pss_pkg::PSS_DONE;
                    end
                end
                pss_pkg::PSS_DONE: begin
                    phase_r <= pss_pkg::PSS_DONE;
                end
                default: begin
                    phase_r <= pss_pkg::PSS_CMD;
                end
            endcase
        end
    end

    // Held across frames so the main domain reads them after the toggle
    always_ff @(posedge sclk_i or negedge link_en_i) begin
        if (!link_en_i) begin
            cmd_o <= 8'h00;
            wr_data_o <= 8'h00;
            acc_tgl_o <= 1'b0;
            wr_tgl_o <= 1'b0;
        end else if (cs_i) begin
            if (phase_r == pss_pkg::PSS_CMD && byte_end) begin
                cmd_o <= byte_in; // [R1]
                acc_tgl_o <= ~acc_tgl_o;
            end
            if (phase_r == pss_pkg::PSS_DATA && byte_end && cmd_o[pss_pkg::CMD_RW_BIT]) begin
                wr_data_o <= byte_in; // [R2]
                wr_tgl_o <= ~wr_tgl_o;
            end
        end
    end

    // Read bits leave on falling edges, LSB first
    always_ff @(negedge sclk_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            io_oe_o <= 1'b0;
            io_o <= 1'b0;
        end else if (phase_r == pss_pkg::PSS_DATA && !cmd_o[pss_pkg::CMD_RW_BIT]) begin
            io_oe_o <= 1'b1; // [R4] [R2]
            io_o <= rd_byte[cnt_r];
        end else begin
            io_oe_o <= 1'b0;
            io_o <= 1'b0;
        end
    end
endmodule : pss_link

// File: src/pss_top.sv
// Supervisor: reset generation, SRAM enable gating, alarm interrupt, registers
module pss_top #(
    parameter int PU_TICKS = pss_pkg::PU_TICKS,
    parameter int PB_TICKS = pss_pkg::PB_TICKS,
    parameter int DB_TICKS = pss_pkg::DB_TICKS,
    parameter int WD_TICKS = pss_pkg::WD_TICKS,
    parameter int XTAL_LOSS_CYC = pss_pkg::XTAL_LOSS_CYC
) (
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic RSTN_I,
    // Crystal and supply comparator
    input wire logic XTAL_I,
    input wire logic SUPPLY_OK_I,
    // Serial link
    input wire logic SCLK_I,
    input wire logic CS_I,
    input wire logic IO_I,
    output logic IO_O,
    output logic IO_OE_O,
    // Processor reset, open drain
    input wire logic RST_I,
    output logic RST_O,
    output logic RST_OE_O,
    // Watchdog
    input wire logic WATCHDOG_KICK_N_I,
    // SRAM enables
    input wire logic RAM_ENABLE_IN_N_I,
    input wire logic LOW_BYTE_SEL_N_I,
    input wire logic HIGH_BYTE_SEL_N_I,
    output logic SRAM_LOW_ENABLE_N_O,
    output logic SRAM_HIGH_ENABLE_N_O,
    // Alarm
    input wire logic ALARM_MATCH_I,
    output logic INT_O
);
    logic [pss_pkg::SYN_W-1:0] syn_raw;
    logic [pss_pkg::SYN_W-1:0] syn1_r;
    logic [pss_pkg::SYN_W-1:0] syn2_r;
    logic [pss_pkg::SYN_W-1:0] syn3_r;

    logic xtal_tick;
    logic kick_fall;
    logic acc_evt;
    logic wr_evt;

    logic [pss_pkg::CNT_W-1:0] loss_cnt_r;
    logic xtal_ok_r;
    logic [pss_pkg::CNT_W-1:0] pu_cnt_r;
    logic pu_done_r;
    logic alive;
    logic [pss_pkg::CNT_W-1:0] db_cnt_r;
    logic [pss_pkg::CNT_W-1:0] pb_cnt_r;
    logic pulse_r;
    logic [pss_pkg::CNT_W-1:0] wd_cnt_r;
    logic wd_fire;
    logic pb_fire;
    logic rst_drive;

    logic link_en_r;
    logic link_acc_tgl;
    logic link_wr_tgl;
    logic [7:0] link_cmd;
    logic [7:0] link_wr_data;

    logic [7:0] regs_r [pss_pkg::NUM_REGS];
    logic [7:0] image_nxt [pss_pkg::NUM_REGS];
    logic [47:0] image_r;
    logic alarm_pending_flag_r;
    logic alarm_pending_flag_nxt;
    logic alarm_acc;
    logic [2:0] acc_idx;
    logic [2:0] wr_idx;

    // Serial logic on its own clock
    pss_link u_link (
        .sclk_i(SCLK_I),
        .cs_i(CS_I),
        .io_i(IO_I),
        .io_o(IO_O),
        .io_oe_o(IO_OE_O),
        .link_en_i(link_en_r),
        .reg_image_i(image_r),
        .acc_tgl_o(link_acc_tgl),
        .wr_tgl_o(link_wr_tgl),
        .cmd_o(link_cmd),
        .wr_data_o(link_wr_data)
    );

    // Main-domain pins other than the alarm match, and link toggles, pass two flops before any use
    assign syn_raw = {link_wr_tgl, link_acc_tgl, CS_I, HIGH_BYTE_SEL_N_I, LOW_BYTE_SEL_N_I,
                      RAM_ENABLE_IN_N_I, WATCHDOG_KICK_N_I, RST_I, SUPPLY_OK_I, XTAL_I};

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            syn1_r <= pss_pkg::SYN_RESET;
            syn2_r <= pss_pkg::SYN_RESET;
            syn3_r <= pss_pkg::SYN_RESET;
        end else begin
            syn1_r <= syn_raw;
            syn2_r <= syn1_r;
            syn3_r <= syn2_r;
        end
    end

    assign xtal_tick = syn2_r[pss_pkg::S_XTAL] & ~syn3_r[pss_pkg::S_XTAL]; // [R14]
    assign kick_fall = ~syn2_r[pss_pkg::S_KICK] & syn3_r[pss_pkg::S_KICK];
    assign acc_evt = syn2_r[pss_pkg::S_ACC] ^ syn3_r[pss_pkg::S_ACC];
    assign wr_evt = syn2_r[pss_pkg::S_WR] ^ syn3_r[pss_pkg::S_WR];

    // Crystal watchdog: no edge for several periods stops the device
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            loss_cnt_r <= '0;
            xtal_ok_r <= 1'b0;
        end else if (xtal_tick) begin
            loss_cnt_r <= '0;
            xtal_ok_r <= 1'b1; // [R14]
        end else if (loss_cnt_r >= XTAL_LOSS_CYC[pss_pkg::CNT_W-1:0]) begin
            xtal_ok_r <= 1'b0; // [R14]
        end else begin
            loss_cnt_r <= loss_cnt_r + 1'b1;
        end
    end

    // Power-up hold, restarted by any supply fault or crystal loss
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            pu_cnt_r <= '0;
            pu_done_r <= 1'b0;
        end else if (!syn2_r[pss_pkg::S_SUPPLY] || !xtal_ok_r) begin
            pu_cnt_r <= '0; // [R12]
            pu_done_r <= 1'b0;
        end else if (xtal_tick && !pu_done_r) begin
            pu_cnt_r <= pu_cnt_r + 1'b1;
            pu_done_r <= (pu_cnt_r == PU_TICKS[pss_pkg::CNT_W-1:0] - 1'b1); // [R12]
        end
    end

    assign alive = pu_done_r & syn2_r[pss_pkg::S_SUPPLY] & xtal_ok_r; // [R13]

    // Button: our own drive is not mistaken for a press
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            db_cnt_r <= '0;
        end else if (!alive || RST_OE_O || syn2_r[pss_pkg::S_RSTPIN]) begin
            db_cnt_r <= '0;
        end else if (xtal_tick && !pb_fire) begin
            db_cnt_r <= db_cnt_r + 1'b1; // [R10] [R19]
        end
    end

    assign pb_fire = (db_cnt_r == DB_TICKS[pss_pkg::CNT_W-1:0]);

    // Watchdog restarts on each kick and during any reset
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            wd_cnt_r <= '0;
        end else if (!alive || pulse_r || kick_fall) begin
            wd_cnt_r <= '0; // [R8]
        end else if (xtal_tick) begin
            wd_cnt_r <= wd_cnt_r + 1'b1; // [R19]
        end
    end

    assign wd_fire = (wd_cnt_r == WD_TICKS[pss_pkg::CNT_W-1:0]); // [R8]

    // Fixed-width reset pulse shared by button and watchdog
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            pb_cnt_r <= '0;
            pulse_r <= 1'b0;
        end else if (!alive) begin
            pb_cnt_r <= '0;
            pulse_r <= 1'b0;
        end else if (!pulse_r && (pb_fire || wd_fire)) begin
            pb_cnt_r <= '0;
            pulse_r <= 1'b1; // [R10] [R8]
        end else if (pulse_r && xtal_tick) begin
            pb_cnt_r <= pb_cnt_r + 1'b1;
            if (pb_cnt_r == PB_TICKS[pss_pkg::CNT_W-1:0] - 1'b1) begin
                pulse_r <= 1'b0; // [R10]
            end
        end
    end

    assign rst_drive = ~alive | pulse_r; // [R9]

    // Open drain: output level fixed low, only the enable moves
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            RST_O <= 1'b0;
        end else begin
            RST_O <= 1'b0; // [R11]
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            RST_OE_O <= 1'b1;
        end else begin
            RST_OE_O <= rst_drive; // [R9] [R11]
        end
    end

    // Serial link held in reset until the device is alive
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            link_en_r <= 1'b0;
        end else begin
            link_en_r <= alive; // [R13]
        end
    end

    // SRAM gating; three-flop pin latency traded for clean timing
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            SRAM_LOW_ENABLE_N_O <= 1'b1;
        end else begin
            SRAM_LOW_ENABLE_N_O <= ~(alive & ~syn2_r[pss_pkg::S_RAM]
                                   & ~syn2_r[pss_pkg::S_LOW]); // [R6] [R18] [R13]
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            SRAM_HIGH_ENABLE_N_O <= 1'b1;
        end else begin
            SRAM_HIGH_ENABLE_N_O <= ~(alive & ~syn2_r[pss_pkg::S_RAM]
                                    & ~syn2_r[pss_pkg::S_HIGH]); // [R7] [R18] [R13]
        end
    end

    // Register file
    assign acc_idx = pss_pkg::pss_index(link_cmd[6:0]);
    assign wr_idx = acc_idx;
    assign alarm_acc = acc_evt && (acc_idx < pss_pkg::IDX_CONTROL); // [R15]

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            for (int i = 0; i < pss_pkg::IDX_CONTROL; i++) begin
                regs_r[i] <= pss_pkg::ALARM_RESET;
            end
            regs_r[pss_pkg::IDX_CONTROL] <= pss_pkg::CTRL_RESET;
            regs_r[pss_pkg::IDX_STATUS] <= 8'h00;
        end else if (wr_evt && alive) begin
            if (wr_idx == pss_pkg::IDX_CONTROL) begin
                // Only the protect bit of control stays writable so protection can be lifted
                if (regs_r[pss_pkg::IDX_CONTROL][pss_pkg::CTRL_WP_BIT]) begin
                    regs_r[pss_pkg::IDX_CONTROL][pss_pkg::CTRL_WP_BIT] <=
                        link_wr_data[pss_pkg::CTRL_WP_BIT]; // [R17]
                end else begin
                    regs_r[pss_pkg::IDX_CONTROL] <= link_wr_data & pss_pkg::CTRL_WMASK;
                end
            end else if (wr_idx < pss_pkg::IDX_CONTROL
                         && !regs_r[pss_pkg::IDX_CONTROL][pss_pkg::CTRL_WP_BIT]) begin
                regs_r[wr_idx] <= link_wr_data; // [R17]
            end
        end
    end

    // Match wins over a clearing access in the same cycle
    always_comb begin
        alarm_pending_flag_nxt = alarm_pending_flag_r;
        if (alarm_acc) begin
            alarm_pending_flag_nxt = 1'b0; // [R15]
        end
        if (ALARM_MATCH_I) begin
            alarm_pending_flag_nxt = 1'b1; // [R15]
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            alarm_pending_flag_r <= 1'b0;
        end else begin
            alarm_pending_flag_r <= alarm_pending_flag_nxt;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            INT_O <= 1'b0;
        end else begin
            INT_O <= alarm_pending_flag_r & regs_r[pss_pkg::IDX_CONTROL][pss_pkg::CTRL_AIE_BIT]; // [R5] [R16]
        end
    end

    // Read image frozen while chip select is high
    generate
        for (genvar g = 0; g < pss_pkg::NUM_REGS; g++) begin : g_img
            if (g == pss_pkg::IDX_STATUS) begin : g_stat
                assign image_nxt[g] = {7'h00, alarm_pending_flag_r};
            end else begin : g_reg
                assign image_nxt[g] = regs_r[g];
            end
            always_ff @(posedge CLOCK_I) begin
                if (!RSTN_I) begin
                    image_r[g*8 +: 8] <= 8'h00;
                end else if (!syn2_r[pss_pkg::S_CS]) begin
                    image_r[g*8 +: 8] <= image_nxt[g]; // [R3]
                end
            end
        end
    endgenerate
endmodule : pss_top

// File: dv/pss_top_chk.sv
// Port-level assertions for the supervisor, bound to its top module
module pss_top_chk #(
    parameter int PB_TICKS = 8
) (
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic RSTN_I,
    // Observed pins
    input wire logic XTAL_I,
    input wire logic SUPPLY_OK_I,
    input wire logic CS_I,
    input wire logic IO_OE_O,
    input wire logic RST_O,
    input wire logic RST_OE_O,
    input wire logic RAM_ENABLE_IN_N_I,
    input wire logic LOW_BYTE_SEL_N_I,
    input wire logic HIGH_BYTE_SEL_N_I,
    input wire logic SRAM_LOW_ENABLE_N_O,
    input wire logic SRAM_HIGH_ENABLE_N_O,
    input wire logic INT_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] xs_r;
    logic [16:0] hi_r;
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RSTN_I);
    // Crystal ticks counted while reset is driven, to catch a short pulse
    always_ff @(posedge CLOCK_I) begin
        xs_r <= {xs_r[1:0], XTAL_I};
    end
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I || !RST_OE_O) begin
            hi_r <= 17'h0;
        end else if (xs_r[1] && !xs_r[2]) begin
            hi_r <= hi_r + 17'h1;
        end
    end
    AST_DRIVE_LOW_ONLY: assert property (RST_O == 1'b0)
        else $error("reset pin driven high");
    AST_LOW_EN: assert property (!SRAM_LOW_ENABLE_N_O |->
        !$past(RAM_ENABLE_IN_N_I, 3) && !$past(LOW_BYTE_SEL_N_I, 3))
        else $error("low enable without both selects");
    AST_HIGH_EN: assert property (!SRAM_HIGH_ENABLE_N_O |->
        !$past(RAM_ENABLE_IN_N_I, 3) && !$past(HIGH_BYTE_SEL_N_I, 3))
        else $error("high enable without both selects");
    AST_RAM_OFF: assert property ($past(RAM_ENABLE_IN_N_I, 3) |->
        SRAM_LOW_ENABLE_N_O && SRAM_HIGH_ENABLE_N_O)
        else $error("enable active while ram input high");
    AST_FAIL_GATE: assert property (!SUPPLY_OK_I [*6] |->
        SRAM_LOW_ENABLE_N_O && SRAM_HIGH_ENABLE_N_O)
        else $error("enable active during supply fault");
    AST_FAIL_RST: assert property (!SUPPLY_OK_I [*6] |-> RST_OE_O)
        else $error("reset released during supply fault");
    AST_IO_IN_FRAME: assert property (IO_OE_O |-> CS_I)
        else $error("data pin driven outside a frame");
    AST_HOLD_AFTER_SUPPLY: assert property ($rose(SUPPLY_OK_I) |-> RST_OE_O [*8])
        else $error("reset released too soon after supply");
    AST_PULSE_WIDTH: assert property ($fell(RST_OE_O) |-> hi_r >= PB_TICKS - 1)
        else $error("reset pulse too short");
    cover property ($rose(INT_O));
    cover property ($rose(IO_OE_O));
    cover property ($fell(RST_OE_O));
endmodule : pss_top_chk

bind pss_top pss_top_chk #(.PB_TICKS(PB_TICKS)) u_chk (
    .CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .XTAL_I(XTAL_I), .SUPPLY_OK_I(SUPPLY_OK_I),
    .CS_I(CS_I), .IO_OE_O(IO_OE_O), .RST_O(RST_O), .RST_OE_O(RST_OE_O),
    .RAM_ENABLE_IN_N_I(RAM_ENABLE_IN_N_I), .LOW_BYTE_SEL_N_I(LOW_BYTE_SEL_N_I),
    .HIGH_BYTE_SEL_N_I(HIGH_BYTE_SEL_N_I), .SRAM_LOW_ENABLE_N_O(SRAM_LOW_ENABLE_N_O),
    .SRAM_HIGH_ENABLE_N_O(SRAM_HIGH_ENABLE_N_O), .INT_O(INT_O)
);

// File: dv/pss_host.sv
// Host model driving the three-wire serial link
module pss_host (
    // Link pins
    output logic sclk_o,
    output logic cs_o,
    output logic io_o,
    // Device data drive
    input wire logic dev_io_i,
    input wire logic dev_oe_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hoe = 1'b0;
    logic hbit = 1'b0;
    logic lst = 1'b0;
    initial begin
        sclk_o = 1'b0;
        cs_o = 1'b0;
    end
    // Released line shows the inverse of its last level, never a kind value
    assign io_o = dev_oe_i ? dev_io_i : (hoe ? hbit : ~lst);
    task automatic xfer(input logic [7:0] c, input logic [7:0] w, output logic [7:0] r);
        logic [15:0] f;
        f = {w, c};
        r = 8'h00;
        #3 cs_o = 1'b1;
        #40;
        for (int i = 0; i < 16; i++) begin
            hoe = (i < 8) || c[7];
            hbit = f[i];
            lst = hoe ? f[i] : lst;
            #24 sclk_o = 1'b1;
            if (!hoe) begin
                r[i - 8] = io_o;
                lst = io_o;
            end
            #24 sclk_o = 1'b0;
        end
        hoe = 1'b0;
        #24 cs_o = 1'b0;
        #60;
    endtask : xfer
endmodule : pss_host

// File: dv/test_portable_system_supervisor.sv
// Self-checking bench for the supervisor
module test_portable_system_supervisor;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PU = 8;
    localparam int PB = 8;
    localparam int WD = 20;
    logic CLOCK_I = 1'b0;
    logic RSTN_I = 1'b0;
    logic XTAL_I = 1'b0;
    logic SUPPLY_OK_I = 1'b1;
    logic RAM_ENABLE_IN_N_I = 1'b0;
    logic LOW_BYTE_SEL_N_I = 1'b0;
    logic HIGH_BYTE_SEL_N_I = 1'b0;
    logic WATCHDOG_KICK_N_I = 1'b1;
    logic ALARM_MATCH_I = 1'b0;
    logic btn = 1'b0;
    logic kick_en = 1'b1;
    logic xtal_en = 1'b1;
    logic [5:0] div_r = 6'h00;
    logic SCLK_I, CS_I, IO_I, IO_O, IO_OE_O, RST_O, RST_OE_O, INT_O;
    logic SRAM_LOW_ENABLE_N_O, SRAM_HIGH_ENABLE_N_O;
    // Open-drain reset wire with pull-up; button pulls it low too
    wire RST_I = !RST_OE_O && !btn;
    int miscompares = 0;
    int n_tests = 0;

    pss_host u_host (.sclk_o(SCLK_I), .cs_o(CS_I), .io_o(IO_I), .dev_io_i(IO_O),
        .dev_oe_i(IO_OE_O));
    pss_top #(.PU_TICKS(PU), .PB_TICKS(PB), .DB_TICKS(3), .WD_TICKS(WD),
        .XTAL_LOSS_CYC(48)) DUT (
        .CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .XTAL_I(XTAL_I), .SUPPLY_OK_I(SUPPLY_OK_I),
        .SCLK_I(SCLK_I), .CS_I(CS_I), .IO_I(IO_I), .IO_O(IO_O), .IO_OE_O(IO_OE_O),
        .RST_I(RST_I), .RST_O(RST_O), .RST_OE_O(RST_OE_O),
        .WATCHDOG_KICK_N_I(WATCHDOG_KICK_N_I), .RAM_ENABLE_IN_N_I(RAM_ENABLE_IN_N_I),
        .LOW_BYTE_SEL_N_I(LOW_BYTE_SEL_N_I), .HIGH_BYTE_SEL_N_I(HIGH_BYTE_SEL_N_I),
        .SRAM_LOW_ENABLE_N_O(SRAM_LOW_ENABLE_N_O),
        .SRAM_HIGH_ENABLE_N_O(SRAM_HIGH_ENABLE_N_O),
        .ALARM_MATCH_I(ALARM_MATCH_I), .INT_O(INT_O));

    initial begin
        forever #4 CLOCK_I = ~CLOCK_I;
    end
    // Crystal at one tick per 8 clocks keeps the run short; kick every 8 ticks
    always @(posedge CLOCK_I) begin
        if (xtal_en) begin
            div_r <= div_r + 6'h01;
        end
        XTAL_I <= div_r[2];
        WATCHDOG_KICK_N_I <= !(kick_en && div_r == 6'h00);
    end

    task automatic conclude();
        $display("checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chkb(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %b, seen %b", nm, e, g);
        end
    endtask : chkb
    task automatic cyc(input int n);
        repeat (n) @(negedge CLOCK_I);
    endtask : cyc
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_host.xfer({1'b0, a}, 8'h00, d);
        chk("read data", e, d);
    endtask : rd
    task automatic wr(input logic [6:0] a, input logic [7:0] w);
        logic [7:0] d;
        u_host.xfer({1'b1, a}, w, d);
    endtask : wr
    task automatic wait_rst(input logic lv, input int n);
        int k;
        k = 0;
        while (RST_OE_O !== lv && k < n) begin
            @(negedge CLOCK_I);
            k++;
        end
        chkb("reset drive", lv, RST_OE_O);
    endtask : wait_rst
    task automatic pulse_len(input int slack);
        int k;
        k = 0;
        while (RST_OE_O === 1'b1 && k < 4000) begin
            @(negedge CLOCK_I);
            k++;
        end
        chkb("pulse width", 1'b1, k >= PB * 8 - slack);
    endtask : pulse_len
    task automatic alarm();
        @(posedge CLOCK_I) ALARM_MATCH_I <= 1'b1;
        @(posedge CLOCK_I) ALARM_MATCH_I <= 1'b0;
        cyc(3);
    endtask : alarm

    initial begin
        cyc(20);
        chkb("reset in reset", 1'b1, RST_OE_O);
        chkb("low en in reset", 1'b1, SRAM_LOW_ENABLE_N_O);
        chkb("int in reset", 1'b0, INT_O);
        @(posedge CLOCK_I) RSTN_I <= 1'b1;
        cyc(30);
        chkb("high en in hold", 1'b1, SRAM_HIGH_ENABLE_N_O);
        chkb("reset in hold", 1'b1, RST_OE_O);
        chkb("reset level", 1'b0, RST_O);
        wait_rst(1'b0, PU * 8 + 40);
        for (int v = 0; v < 8; v++) begin
            @(posedge CLOCK_I);
            RAM_ENABLE_IN_N_I <= v[2];
            HIGH_BYTE_SEL_N_I <= v[1];
            LOW_BYTE_SEL_N_I <= v[0];
            cyc(4);
            chkb("low enable", v[2] | v[0], SRAM_LOW_ENABLE_N_O);
            chkb("high enable", v[2] | v[1], SRAM_HIGH_ENABLE_N_O);
        end
        rd(7'h0b, 8'h80);
        wr(7'h0b, 8'h01);
        rd(7'h0b, 8'h01);
        wr(7'h07, 8'h5a);
        rd(7'h07, 8'h5a);
        wr(7'h20, 8'hff);
        rd(7'h20, 8'h00);
        alarm();
        chkb("int", 1'b1, INT_O);
        rd(7'h0c, 8'h01);
        chkb("int held", 1'b1, INT_O);
        rd(7'h07, 8'h5a);
        chkb("int read clear", 1'b0, INT_O);
        wr(7'h0b, 8'h00);
        alarm();
        chkb("int masked", 1'b0, INT_O);
        wr(7'h0b, 8'h01);
        cyc(4);
        chkb("int unmasked", 1'b1, INT_O);
        wr(7'h08, 8'h00);
        chkb("int write clear", 1'b0, INT_O);
        wr(7'h0b, 8'h41);
        wr(7'h07, 8'h33);
        rd(7'h07, 8'h5a);
        wr(7'h0b, 8'h01);
        rd(7'h0b, 8'h01);
        cyc(WD * 16);
        chkb("kicked", 1'b0, RST_OE_O);
        @(posedge CLOCK_I) kick_en <= 1'b0;
        wait_rst(1'b1, WD * 8 + 80);
        @(posedge CLOCK_I) kick_en <= 1'b1;
        pulse_len(16);
        @(posedge CLOCK_I) btn <= 1'b1;
        cyc(8);
        @(posedge CLOCK_I) btn <= 1'b0;
        cyc(40);
        chkb("bounce", 1'b0, RST_OE_O);
        @(posedge CLOCK_I) btn <= 1'b1;
        cyc(32);
        @(posedge CLOCK_I) btn <= 1'b0;
        wait_rst(1'b1, 8);
        pulse_len(24);
        @(posedge CLOCK_I);
        SUPPLY_OK_I <= 1'b0;
        RAM_ENABLE_IN_N_I <= 1'b0;
        LOW_BYTE_SEL_N_I <= 1'b0;
        cyc(8);
        chkb("reset on fault", 1'b1, RST_OE_O);
        chkb("low en on fault", 1'b1, SRAM_LOW_ENABLE_N_O);
        wr(7'h07, 8'h11);
        @(posedge CLOCK_I) SUPPLY_OK_I <= 1'b1;
        cyc(40);
        chkb("reset after fault", 1'b1, RST_OE_O);
        wait_rst(1'b0, PU * 8 + 40);
        rd(7'h07, 8'h5a);
        chkb("low en back", 1'b0, SRAM_LOW_ENABLE_N_O);
        @(posedge CLOCK_I) xtal_en <= 1'b0;
        wait_rst(1'b1, 120);
        @(posedge CLOCK_I) xtal_en <= 1'b1;
        wait_rst(1'b0, PU * 8 + 80);
        conclude();
    end
    initial begin
        #100us;
        miscompares++;
        conclude();
    end
endmodule : test_portable_system_supervisor
